/* File: adcbs_step_cfg.sv */
// Step ten and eleven configuration registers of converter B sequencer with APB access.
//
// Behaviour
// - Bit 15 enables step ten; resets to disabled.
// - Gain bits 14:13: 00 gain 1, 01 gain 2, 10 and 11 gain 4.
// - Bits 12:5 are reserved and always read zero.
// - Bit 4 selects negative input: 0 analog ground, 1 external input seven.
// - Positive codes 0000 to 0111 route external inputs zero to seven.
// - Code 1001 shorts inputs to ground internally; negative chosen automatically.
// - Codes 1000, 1010, 1110, 1111 pick internal sources; negative automatic.
// - With an automatic negative code the negative select bit is ignored.
// - Step eleven register at DBh, resets to 000Bh.
// - Step ten register at DAh, resets to 000Ah.
//
// Implementation choice: the APB register port.
`include "adcbs_cfg.svh"
module adcbs_step_cfg
  import adcbs_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 step_ten_active,
  input  wire logic                 step_eleven_active,
  output logic                      step_ten_enable,
  output logic                      step_eleven_enable,
  output adcbs_pkg::adcbs_conv_t    conv_setting
);
  import adcbs_pkg::*;

  // Decode used for both the write strobe and the read select.
  function automatic logic [1:0] reg_hit(input logic [11:0] a);
    reg_hit = {a == `ADCBS_ADDR_STEP_ELEVEN, a == `ADCBS_ADDR_STEP_TEN};
  endfunction

  function automatic adcbs_conv_t decode_step(input logic [15:0] w, input logic act);
    adcbs_conv_t c;
    logic [3:0]  p;
    c = '0;
    p = w[`ADCBS_POS_HI:`ADCBS_POS_LO];
    c.valid = act && w[`ADCBS_BIT_ENABLE];
    case (w[`ADCBS_GAIN_HI:`ADCBS_GAIN_LO])
      2'h0: c.gain = ADCBS_GAIN_X1;
      2'h1: c.gain = ADCBS_GAIN_X2;
      default: c.gain = ADCBS_GAIN_X4;
    endcase
    c.positive = p;
    c.neg_auto = p > `ADCBS_POS_EXT_LAST;
    c.neg_ext_seven = !c.neg_auto && w[`ADCBS_BIT_NEG];
    if (!c.valid) begin
      c = '0;
    end
    return c;
  endfunction

  logic [1:0]  hit;
  logic        access;
  logic        wr_en;
  logic [15:0] word_ten;
  logic [15:0] word_eleven;
  logic [15:0] rd_word;
  logic        rd_phase;
  logic        rd_ok;
  adcbs_conv_t next_conv;

  assign hit    = reg_hit(paddr);
  assign access = psel && penable && !pready;
  // Only the low byte lanes carry register data; a write missing either low lane strobe writes nothing.
  // A write lands on the completing edge, so a stalled access never alters a register.
  assign wr_en  = psel && penable && pready && pwrite && (hit != 2'h0) && (pstrb[1:0] == 2'h3);

  adcbs_step_regs u_regs (
    .pclk        (pclk),
    .presetn     (presetn),
    .wr_en       (wr_en),
    .wr_sel      (hit[1]),
    .wr_data     (pwdata[15:0]),
    .rd_sel      (hit[1]),
    .rd_data     (rd_word),
    .word_ten    (word_ten),
    .word_eleven (word_eleven)
  );

  // Two wait states let the store register its read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_phase <= 1'b0;
    end else begin
      rd_phase <= access;
    end
  end

  // The address is judged once, at the first access edge, and held for the answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ok <= 1'b0;
    end else if (access && !rd_phase) begin
      rd_ok <= hit != 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access && rd_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access && rd_phase && !rd_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access && rd_phase && !pwrite) begin
      prdata <= rd_ok ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  always_comb begin
    next_conv = '0;
    if (step_ten_active) begin
      next_conv = decode_step(word_ten, 1'b1);
    end else if (step_eleven_active) begin
      next_conv = decode_step(word_eleven, 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_setting       <= '0;
      step_ten_enable    <= 1'b0;
      step_eleven_enable <= 1'b0;
    end else begin
      conv_setting       <= next_conv;
      step_ten_enable    <= word_ten[`ADCBS_BIT_ENABLE];
      step_eleven_enable <= word_eleven[`ADCBS_BIT_ENABLE];
    end
  end

  // Register bus answers.
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite |-> prdata[31:16] == 16'h0000 && prdata[12:5] == 8'h00)
    else $error("reserved bits read nonzero");

  a_read_ten: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == `ADCBS_ADDR_STEP_TEN |-> prdata == {16'h0000, word_ten})
    else $error("step ten read wrong");

  a_read_eleven: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == `ADCBS_ADDR_STEP_ELEVEN |-> prdata == {16'h0000, word_eleven})
    else $error("step eleven read wrong");

  a_ready_latency: assert property (@(posedge pclk) disable iff (!presetn)
    psel && $rose(penable) |-> ##2 pready)
    else $error("answer not on time");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> !pready)
    else $error("ready without a transfer");

  a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> psel && penable)
    else $error("ready outside an access");

  a_error_only: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  a_error_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> pslverr == (paddr != `ADCBS_ADDR_STEP_TEN && paddr != `ADCBS_ADDR_STEP_ELEVEN))
    else $error("error flag wrong");

  a_error_data: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");

  a_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read");

  // Register store.
  a_reserved_store: assert property (@(posedge pclk) disable iff (!presetn)
    (word_ten[12:5] == 8'h00) && (word_eleven[12:5] == 8'h00))
    else $error("reserved bits stored");

  a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && !hit[1] |=> word_ten == ($past(pwdata[15:0]) & `ADCBS_WRITE_MASK))
    else $error("write not stored");

  a_write_eleven: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit[1] |=> word_eleven == ($past(pwdata[15:0]) & `ADCBS_WRITE_MASK))
    else $error("step eleven write not stored");

  a_write_hold: assert property (@(posedge pclk) disable iff (!presetn)
    access |=> $stable(word_ten) && $stable(word_eleven))
    else $error("register changed before the answer");

  a_error_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr |=> $stable(word_ten) && $stable(word_eleven))
    else $error("refused write stored");

  a_strobe_partial: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pwrite && pstrb[1:0] != 2'h3 |=> $stable(word_ten) && $stable(word_eleven))
    else $error("partial strobe write stored");

  a_read_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite |=> $stable(word_ten) && $stable(word_eleven))
    else $error("read changed a register");

  // Step outputs toward the sequencer and the converter.
  a_enable_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 step_ten_enable == $past(word_ten[15]))
    else $error("enable mismatch");

  a_eleven_enable: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 step_eleven_enable == $past(word_eleven[15]))
    else $error("step eleven enable mismatch");

  a_gain_map: assert property (@(posedge pclk) disable iff (!presetn)
    step_ten_active && word_ten[15] && word_ten[14] |=> conv_setting.gain == ADCBS_GAIN_X4)
    else $error("gain map wrong");

  a_gain_unit: assert property (@(posedge pclk) disable iff (!presetn)
    step_ten_active && word_ten[15] && word_ten[14:13] == 2'h0 |=>
      conv_setting.gain == ADCBS_GAIN_X1)
    else $error("unit gain wrong");

  a_gain_double: assert property (@(posedge pclk) disable iff (!presetn)
    step_ten_active && word_ten[15] && word_ten[14:13] == 2'h1 |=>
      conv_setting.gain == ADCBS_GAIN_X2)
    else $error("double gain wrong");

  a_gain_legal: assert property (@(posedge pclk) disable iff (!presetn)
    conv_setting.gain != 2'h3)
    else $error("gain code out of range");

  a_neg_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    step_ten_active && word_ten[3] |=> !conv_setting.neg_ext_seven)
    else $error("negative select not ignored");

  a_eleven_neg: assert property (@(posedge pclk) disable iff (!presetn)
    !step_ten_active && step_eleven_active && word_eleven[3] |=> !conv_setting.neg_ext_seven)
    else $error("step eleven negative select not ignored");

  a_neg_select: assert property (@(posedge pclk) disable iff (!presetn)
    step_ten_active && word_ten[15] && !word_ten[3] |=>
    conv_setting.neg_ext_seven == $past(word_ten[4]))
    else $error("negative select wrong");

  a_neg_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    conv_setting.neg_auto |-> !conv_setting.neg_ext_seven)
    else $error("automatic and external negative together");

  a_positive_pass: assert property (@(posedge pclk) disable iff (!presetn)
    step_ten_active && word_ten[15] |=> conv_setting.positive == $past(word_ten[3:0]) &&
    conv_setting.neg_auto == $past(word_ten[3]))
    else $error("positive route wrong");

  a_auto_code: assert property (@(posedge pclk) disable iff (!presetn)
    conv_setting.valid |-> conv_setting.neg_auto == conv_setting.positive[3])
    else $error("automatic negative flag wrong");

  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !step_ten_active && !step_eleven_active |=> !conv_setting.valid)
    else $error("setting applied outside step");

  a_invalid_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !conv_setting.valid |-> conv_setting == '0)
    else $error("stale setting left on converter");

  a_ten_priority: assert property (@(posedge pclk) disable iff (!presetn)
    step_ten_active && step_eleven_active && word_ten[15] |=>
      conv_setting.positive == $past(word_ten[3:0]))
    else $error("step ten did not take priority");

  a_disabled_skip: assert property (@(posedge pclk) disable iff (!presetn)
    step_ten_active && !word_ten[15] |=> conv_setting == '0)
    else $error("disabled step applied");

  a_eleven_route: assert property (@(posedge pclk) disable iff (!presetn)
    !step_ten_active && step_eleven_active && word_eleven[15] |=>
      conv_setting.valid && conv_setting.positive == $past(word_eleven[3:0]))
    else $error("step eleven route wrong");

  a_eleven_skip: assert property (@(posedge pclk) disable iff (!presetn)
    !step_ten_active && step_eleven_active && !word_eleven[15] |=>
      conv_setting == '0)
    else $error("disabled step eleven applied");
endmodule

/* File: adcbs_cfg.svh */
// Offsets, field positions, reset values and codes for the step configuration block.
`ifndef ADCBS_CFG_SVH
`define ADCBS_CFG_SVH
`define ADCBS_IDX_STEP_TEN      8'hda
`define ADCBS_IDX_STEP_ELEVEN   8'hdb
`define ADCBS_ADDR_STEP_TEN     12'h368
`define ADCBS_ADDR_STEP_ELEVEN  12'h36c
`define ADCBS_RST_STEP_TEN      16'h000a
`define ADCBS_RST_STEP_ELEVEN   16'h000b
`define ADCBS_BIT_ENABLE        15
`define ADCBS_GAIN_HI           14
`define ADCBS_GAIN_LO           13
`define ADCBS_BIT_NEG           4
`define ADCBS_POS_HI            3
`define ADCBS_POS_LO            0
`define ADCBS_WRITE_MASK        16'he01f
`define ADCBS_POS_EXT_LAST      4'h7
`define ADCBS_POS_TEMP          4'h8
`define ADCBS_POS_SHORT         4'h9
`define ADCBS_POS_TEST_DAC      4'ha
`define ADCBS_POS_ANALOG_POWER_SUPPLY          4'he
`define ADCBS_POS_DIGITAL_POWER_SUPPLY          4'hf
`endif

/* File: adcbs_pkg.sv */
// Types shared by the step configuration block.
package adcbs_pkg;
  typedef enum logic [1:0] {
    ADCBS_GAIN_X1,
    ADCBS_GAIN_X2,
    ADCBS_GAIN_X4
  } adcbs_gain_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  gain;
    logic        neg_ext_seven;
    logic        neg_auto;
    logic [3:0]  positive;
  } adcbs_conv_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } adcbs_apb_req_t;
endpackage

/* File: adcbs_step_regs.sv */
// Two-word step configuration store with registered read data.
`include "adcbs_cfg.svh"
module adcbs_step_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic        wr_sel,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_sel,
  output logic      [15:0] rd_data,
  output logic      [15:0] word_ten,
  output logic      [15:0] word_eleven
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_ten <= `ADCBS_RST_STEP_TEN;
    end else if (wr_en && !wr_sel) begin
      word_ten <= wr_data & `ADCBS_WRITE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_eleven <= `ADCBS_RST_STEP_ELEVEN;
    end else if (wr_en && wr_sel) begin
      word_eleven <= wr_data & `ADCBS_WRITE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= rd_sel ? word_eleven : word_ten;
    end
  end
endmodule

/* File: adcbs_step_cfg_tb.sv */
// Self-checking bench for the step ten and eleven configuration registers over APB.
`include "adcbs_cfg.svh"
module testbench
  import adcbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic        act10, act11, en10, en11;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [3:0]  pstrb, p;
  adcbs_conv_t conv, x;
  int          err_total, n_checks;

  adcbs_step_cfg DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_ten_active(act10),
    .step_eleven_active(act11), .step_ten_enable(en10), .step_eleven_enable(en11),
    .conv_setting(conv));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Each transfer starts one edge after the last release, so no signal is driven twice.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait that never gets an answer.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rq, exp);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    results;
  end

  initial begin
    {presetn, psel, penable, pwrite, act10, act11} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ADCBS_ADDR_STEP_TEN, 32'h0000000a);
    chk(re, 1'b0);
    rd(`ADCBS_ADDR_STEP_ELEVEN, 32'h0000000b);
    chk(en10, 1'b0);
    chk(conv, 32'h0);
    $display("reset test done");
    apb(1'b1, `ADCBS_ADDR_STEP_TEN, 32'hffffffff);
    rd(`ADCBS_ADDR_STEP_TEN, 32'h0000e01f);
    pstrb <= 4'hc;
    apb(1'b1, `ADCBS_ADDR_STEP_TEN, 32'h0);
    pstrb <= 4'hf;
    rd(`ADCBS_ADDR_STEP_TEN, 32'h0000e01f);
    apb(1'b1, 12'h370, 32'hffffffff);
    chk(re, 1'b1);
    rd(12'h370, 32'h0);
    chk(re, 1'b1);
    $display("access test done");
    // Bit four stays set so that every code from eight up shows it is ignored.
    for (int c = 0; c < 16; c++) begin
      p = c[3:0];
      apb(1'b1, `ADCBS_ADDR_STEP_TEN, {16'h0, 1'b1, p[1:0], 8'h00, 1'b1, p});
      act10 <= 1'b1;
      repeat (2) @(posedge pclk);
      x.valid = 1'b1;
      x.gain = p[1] ? ADCBS_GAIN_X4 : (p[0] ? ADCBS_GAIN_X2 : ADCBS_GAIN_X1);
      x.neg_ext_seven = ~p[3];
      x.neg_auto = p[3];
      x.positive = p;
      chk(conv, x);
      chk(en10, 1'b1);
      act10 <= 1'b0;
    end
    $display("code sweep done");
    apb(1'b1, `ADCBS_ADDR_STEP_TEN, 32'h00006003);
    act10 <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(conv, 32'h0);
    chk(en10, 1'b0);
    act10 <= 1'b0;
    apb(1'b1, `ADCBS_ADDR_STEP_ELEVEN, 32'h00008015);
    act11 <= 1'b1;
    repeat (2) @(posedge pclk);
    x = '{1'b1, 2'h0, 1'b1, 1'b0, 4'h5};
    chk(conv, x);
    chk(en11, 1'b1);
    act11 <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(conv, 32'h0);
    $display("step test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ADCBS_ADDR_STEP_TEN, 32'h0000000a);
    rd(`ADCBS_ADDR_STEP_ELEVEN, 32'h0000000b);
    chk(en11, 1'b0);
    chk(en10, 1'b0);
    $display("second reset test done");
    results;
  end
endmodule
